// [verilog/vic_pkg.sv]
// Package of register offsets, field positions and sizes for the vectored interrupt controller.
package vic_pkg;
   // ****************************************************************
   // Sizes
   // ****************************************************************
   localparam int NSRC = 32;                 // Number of interrupt sources.
   localparam int PRIO_W = 3;                // Width of a priority level.
   localparam int TRIG_W = 2;                // Width of the trigger type field.
   localparam int SRC_IW = 5;                // Width of a source number.
   localparam int STACK_N = 8;               // Depth of the priority stack.
   localparam int DEPTH_W = 4;               // Width of the stack fill count.
   localparam int ADDR_W = 12;               // Byte address bits of the window.
   localparam int WINDOW_BYTES = 4096;       // Size of the decoded window.
   localparam logic [31:0] BASE_ADDR = 32'hffff_f000; // System base of the window.

   // ****************************************************************
   // Byte offsets
   // ****************************************************************
   localparam logic [11:0] OFF_MODE0 = 12'h000;
   localparam logic [11:0] OFF_MODE_LAST = 12'h07c;
   localparam logic [11:0] OFF_VEC0 = 12'h080;
   localparam logic [11:0] OFF_VEC_LAST = 12'h0fc;
   localparam logic [11:0] OFF_NVEC = 12'h100;
   localparam logic [11:0] OFF_FVEC = 12'h104;
   localparam logic [11:0] OFF_CUR = 12'h108;
   localparam logic [11:0] OFF_PEND = 12'h10c;
   localparam logic [11:0] OFF_ENA = 12'h110;
   localparam logic [11:0] OFF_CORE = 12'h114;
   localparam logic [11:0] OFF_ENCMD = 12'h120;
   localparam logic [11:0] OFF_DISCMD = 12'h124;
   localparam logic [11:0] OFF_CLRCMD = 12'h128;
   localparam logic [11:0] OFF_SETCMD = 12'h12c;
   localparam logic [11:0] OFF_EOS = 12'h130;
   localparam logic [11:0] OFF_SPU = 12'h134;
   localparam logic [11:0] OFF_DBG = 12'h138;
   localparam logic [11:0] OFF_FFEN = 12'h140;
   localparam logic [11:0] OFF_FFDIS = 12'h144;
   localparam logic [11:0] OFF_FFST = 12'h148;

   // ****************************************************************
   // Field positions and reset values
   // ****************************************************************
   localparam int PRIO_LSB = 0;              // Priority level in a mode word.
   localparam int TRIG_LSB = 5;              // Trigger type in a mode word.
   localparam int DBG_PROTECT_MODE_BIT_BIT = 0;          // Protect mode bit of the debug word.
   localparam int DBG_GLOBAL_MASK_BIT_BIT = 1;          // Global mask bit of the debug word.
   localparam int CORE_FAST_BIT = 0;         // Fast line status bit.
   localparam int CORE_NORM_BIT = 1;         // Normal line status bit.
   localparam int FAST_SRC = 0;              // Source wired to the fast line.
   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [31:0] FORCE_ALLOWED = 32'hffff_fffe; // Source 0 cannot be forced.
endpackage : vic_pkg

// [verilog/vic_sel_if.sv]
// Interface carrying candidates and the chosen source between the controller and its selector.
`timescale 1ns/100ps
interface vic_sel_if #(parameter int NSRC = 32, parameter int PW = 3, parameter int IW = 5);
   logic [NSRC-1:0] cand;                    // Sources eligible for the normal line.
   logic [NSRC*PW-1:0] prio;                 // Priority of each source, packed.
   logic found;                              // At least one candidate exists.
   logic [IW-1:0] id;                        // Winning source number.
   logic [PW-1:0] lvl;                       // Winning priority level.
   modport req (output cand, output prio, input found, input id, input lvl);
   modport sel (input cand, input prio, output found, output id, output lvl);
endinterface : vic_sel_if

// [verilog/vic_prio_sel.sv]
// Highest-priority source selector for the normal interrupt line.
`timescale 1ns/100ps
module vic_prio_sel #(
   parameter int NSRC = 32,
   parameter int PW = 3,
   parameter int IW = 5
) (
   vic_sel_if.sel s
);
   // ****************************************************************
   // Selection
   // ****************************************************************
   // A later source replaces the winner only with a strictly higher level,
   // so among equal levels the lowest source number wins.
   always_comb begin
      s.found = 1'b0;
      s.id = '0;
      s.lvl = '0;
      for (int i = 0; i < NSRC; i++) begin
         if (s.cand[i] && (!s.found || (s.prio[i*PW +: PW] > s.lvl))) begin
            s.found = 1'b1;
            s.id = IW'(i);
            s.lvl = s.prio[i*PW +: PW];
         end
      end
   end
endmodule : vic_prio_sel

// [verilog/vic_ctrl.sv]
// Register interface and vectoring core of the 32-source interrupt controller.
//
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/100ps
module vic_ctrl #(
   parameter int NSRC = vic_pkg::NSRC
) (
   input wire logic clock,
   input wire logic reset_n,
   input wire logic [11:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [NSRC-1:0] src_in,
   output logic normal_request_line_n,
   output logic fast_request_line_n,
   output logic wakeup_req
);
   localparam int PW = vic_pkg::PRIO_W;
   localparam int IW = vic_pkg::SRC_IW;
   localparam int SN = vic_pkg::STACK_N;

   // ****************************************************************
   // State
   // ****************************************************************
   logic [NSRC-1:0] sync1_ff;                // First synchroniser stage of the sources.
   logic [NSRC-1:0] sync2_ff;                // Second stage; the only one logic reads.
   logic [NSRC-1:0] prev_ff;                 // Previous sampled level for edge detection.
   logic [PW-1:0] prio_ff [NSRC];            // Priority field of each mode word.
   logic [PW-1:0] nxt_prio [NSRC];
   logic [1:0] trig_ff [NSRC];               // Trigger type field of each mode word.
   logic [1:0] nxt_trig [NSRC];
   logic [31:0] vector_ff [NSRC];            // Handler vector words.
   logic [31:0] nxt_vector [NSRC];
   logic [31:0] spu_ff, nxt_spu;             // Vector returned when no request is active.
   logic protect_mode_bit_ff, nxt_protect_mode_bit;                  // Protect mode bit.
   logic global_mask_bit_ff, nxt_global_mask_bit;                  // Global mask bit.
   logic [NSRC-1:0] enabled_ff, nxt_enabled; // Per-source enable.
   logic [NSRC-1:0] force_ff, nxt_force;     // Per-source fast redirection.
   logic [NSRC-1:0] edge_pend_ff, nxt_edge_pend; // Latched edge requests.
   logic [PW-1:0] cur_lvl_ff, nxt_cur_lvl;   // Level of the interrupt in service.
   logic [IW-1:0] cur_src_ff, nxt_cur_src;   // Number of the interrupt in service.
   logic [vic_pkg::DEPTH_W-1:0] depth_ff, nxt_depth; // Stacked entries.
   logic [PW-1:0] stk_lvl_ff [SN];           // Saved levels.
   logic [PW-1:0] nxt_stk_lvl [SN];
   logic [IW-1:0] stk_src_ff [SN];           // Saved source numbers.
   logic [IW-1:0] nxt_stk_src [SN];
   logic memo_valid_ff, nxt_memo_valid;      // A protect-mode read found a source.
   logic [IW-1:0] memo_src_ff, nxt_memo_src; // Source memorized by that read.
   logic [PW-1:0] memo_lvl_ff, nxt_memo_lvl; // Its level.
   logic wait_ff, nxt_wait;                  // Drives waitrequest.
   logic [31:0] rdata_ff, nxt_rdata;         // Drives readdata.
   logic normal_request_line_n_ff, nxt_normal_request_line_n;              // Normal line, active low.
   logic fast_request_line_n_ff, nxt_fast_request_line_n;              // Fast line, active low.
   logic wake_ff, nxt_wake;                  // Wake request, not masked.

   // ****************************************************************
   // Decoded view
   // ****************************************************************
   logic [NSRC-1:0] edge_mode;               // Source is edge triggered.
   logic [NSRC-1:0] pending;                 // Pending word contents.
   logic [NSRC-1:0] live;                    // Pending and enabled.
   logic active;                             // A source beats the current level, or any source when the stack is empty.
   logic fast_hit;                           // Fast line has a cause.
   logic acc;                                // A bus request is taken this cycle.
   logic [31:0] bmask;                       // Byte-enable mask.
   logic [31:0] wdm;                         // Masked write data.
   logic [9:0] widx;                         // Word index within the window.

   vic_sel_if #(.NSRC(NSRC), .PW(PW), .IW(IW)) sel_bus ();

   vic_prio_sel #(.NSRC(NSRC), .PW(PW), .IW(IW)) u_sel (
      .s (sel_bus.sel)
   );

   // Builds the read view of a mode word from its two fields.
   function automatic logic [31:0] mode_word(input logic [PW-1:0] p, input logic [1:0] t);
      logic [31:0] w;
      w = vic_pkg::RST_WORD;
      w[vic_pkg::PRIO_LSB +: PW] = p;
      w[vic_pkg::TRIG_LSB +: vic_pkg::TRIG_W] = t;
      return w;
   endfunction : mode_word

   // Returns true when the byte address hits the given register offset.
   function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
      return a[11:2] == off[11:2];
   endfunction : hit

   // ****************************************************************
   // Source view and line causes
   // ****************************************************************
   // Level sources read their synchronised input directly, so after reset a
   // held external level shows as pending at once; prev_ff resets to zero, so it also latches as an edge in the first cycle.
   always_comb begin
      for (int i = 0; i < NSRC; i++) begin
         edge_mode[i] = trig_ff[i][0];
         pending[i] = edge_mode[i] ? edge_pend_ff[i] : sync2_ff[i];
         sel_bus.prio[i*PW +: PW] = prio_ff[i];
      end
      live = pending & enabled_ff;
      // Source zero and redirected sources never reach the priority handler.
      sel_bus.cand = live & ~force_ff & vic_pkg::FORCE_ALLOWED;
      active = sel_bus.found && ((depth_ff == '0) || (sel_bus.lvl > cur_lvl_ff));
      fast_hit = live[vic_pkg::FAST_SRC] || (|(live & force_ff));
      bmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
               {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
      wdm = avs_writedata & bmask;
      widx = avs_address[11:2];
      acc = (avs_read || avs_write) && wait_ff;
   end

   // ****************************************************************
   // Next-state logic
   // ****************************************************************
   // The whole register file and the stack move in one process because a
   // single access can touch both, for example a vector read that stacks.
   always_comb begin
      logic [31:0] mw;
      logic do_push;
      logic [IW-1:0] push_src;
      logic [PW-1:0] push_lvl;
      logic [NSRC-1:0] set_v;
      logic [NSRC-1:0] clr_v;
      mw = vic_pkg::RST_WORD;
      do_push = 1'b0;
      push_src = '0;
      push_lvl = '0;
      set_v = (sync2_ff & ~prev_ff);
      clr_v = '0;
      nxt_prio = prio_ff;
      nxt_trig = trig_ff;
      nxt_vector = vector_ff;
      nxt_spu = spu_ff;
      nxt_protect_mode_bit = protect_mode_bit_ff;
      nxt_global_mask_bit = global_mask_bit_ff;
      nxt_enabled = enabled_ff;
      nxt_force = force_ff;
      nxt_cur_lvl = cur_lvl_ff;
      nxt_cur_src = cur_src_ff;
      nxt_depth = depth_ff;
      nxt_stk_lvl = stk_lvl_ff;
      nxt_stk_src = stk_src_ff;
      nxt_memo_valid = memo_valid_ff;
      nxt_memo_src = memo_src_ff;
      nxt_memo_lvl = memo_lvl_ff;
      nxt_rdata = rdata_ff;
      // One wait cycle per transfer: taken with wait high, completed with it low.
      nxt_wait = !acc;
      // Reads: data is chosen at the edge where the request is taken.
      if (acc && avs_read) begin
         nxt_rdata = vic_pkg::RST_WORD;
         if (avs_address < vic_pkg::OFF_VEC0) begin
            nxt_rdata = mode_word(prio_ff[widx[4:0]], trig_ff[widx[4:0]]);
         end else if (avs_address <= vic_pkg::OFF_VEC_LAST) begin
            nxt_rdata = vector_ff[widx[4:0]];
         end else if (hit(avs_address, vic_pkg::OFF_NVEC)) begin
            if (active) begin
               nxt_rdata = vector_ff[sel_bus.id];
               if (protect_mode_bit_ff) begin
                  // Protect mode only memorizes; a debugger read stays harmless.
                  nxt_memo_valid = 1'b1;
                  nxt_memo_src = sel_bus.id;
                  nxt_memo_lvl = sel_bus.lvl;
               end else begin
                  do_push = 1'b1;
                  push_src = sel_bus.id;
                  push_lvl = sel_bus.lvl;
               end
            end else begin
               nxt_rdata = spu_ff;
               nxt_memo_valid = 1'b0;
            end
         end else if (hit(avs_address, vic_pkg::OFF_FVEC)) begin
            nxt_rdata = fast_hit ? vector_ff[vic_pkg::FAST_SRC] : spu_ff;
            // Only source zero itself is acknowledged; redirected sources
            // must be cleared through the clear command.
            if (live[vic_pkg::FAST_SRC]) begin
               clr_v[vic_pkg::FAST_SRC] = 1'b1;
            end
         end else if (hit(avs_address, vic_pkg::OFF_CUR)) begin
            nxt_rdata = {{(32-IW){1'b0}}, cur_src_ff};
         end else if (hit(avs_address, vic_pkg::OFF_PEND)) begin
            nxt_rdata = pending;
         end else if (hit(avs_address, vic_pkg::OFF_ENA)) begin
            nxt_rdata = enabled_ff;
         end else if (hit(avs_address, vic_pkg::OFF_CORE)) begin
            nxt_rdata[vic_pkg::CORE_FAST_BIT] = !fast_request_line_n_ff;
            nxt_rdata[vic_pkg::CORE_NORM_BIT] = !normal_request_line_n_ff;
         end else if (hit(avs_address, vic_pkg::OFF_SPU)) begin
            nxt_rdata = spu_ff;
         end else if (hit(avs_address, vic_pkg::OFF_DBG)) begin
            nxt_rdata[vic_pkg::DBG_PROTECT_MODE_BIT_BIT] = protect_mode_bit_ff;
            nxt_rdata[vic_pkg::DBG_GLOBAL_MASK_BIT_BIT] = global_mask_bit_ff;
         end else if (hit(avs_address, vic_pkg::OFF_FFST)) begin
            nxt_rdata = force_ff;
         end
      end
      // Writes: read-only and reserved words fall through with no effect.
      if (acc && avs_write) begin
         if (avs_address < vic_pkg::OFF_VEC0) begin
            mw = mode_word(prio_ff[widx[4:0]], trig_ff[widx[4:0]]);
            mw = (mw & ~bmask) | wdm;
            nxt_prio[widx[4:0]] = mw[vic_pkg::PRIO_LSB +: PW];
            nxt_trig[widx[4:0]] = mw[vic_pkg::TRIG_LSB +: vic_pkg::TRIG_W];
         end else if (avs_address <= vic_pkg::OFF_VEC_LAST) begin
            nxt_vector[widx[4:0]] = (vector_ff[widx[4:0]] & ~bmask) | wdm;
         end else if (hit(avs_address, vic_pkg::OFF_NVEC)) begin
            // In normal mode this write is harmless and does nothing.
            if (protect_mode_bit_ff && memo_valid_ff) begin
               do_push = 1'b1;
               push_src = memo_src_ff;
               push_lvl = memo_lvl_ff;
               nxt_memo_valid = 1'b0;
            end
         end else if (hit(avs_address, vic_pkg::OFF_ENCMD)) begin
            nxt_enabled = enabled_ff | wdm;
         end else if (hit(avs_address, vic_pkg::OFF_DISCMD)) begin
            nxt_enabled = enabled_ff & ~wdm;
         end else if (hit(avs_address, vic_pkg::OFF_CLRCMD)) begin
            clr_v = clr_v | wdm;
         end else if (hit(avs_address, vic_pkg::OFF_SETCMD)) begin
            set_v = set_v | wdm;
         end else if (hit(avs_address, vic_pkg::OFF_EOS)) begin
            if (depth_ff != '0) begin
               nxt_depth = depth_ff - 1'b1;
               nxt_cur_lvl = stk_lvl_ff[3'(depth_ff - 1'b1)];
               nxt_cur_src = stk_src_ff[3'(depth_ff - 1'b1)];
            end
         end else if (hit(avs_address, vic_pkg::OFF_SPU)) begin
            nxt_spu = (spu_ff & ~bmask) | wdm;
         end else if (hit(avs_address, vic_pkg::OFF_DBG)) begin
            if (avs_byteenable[0]) begin
               nxt_protect_mode_bit = avs_writedata[vic_pkg::DBG_PROTECT_MODE_BIT_BIT];
               nxt_global_mask_bit = avs_writedata[vic_pkg::DBG_GLOBAL_MASK_BIT_BIT];
            end
         end else if (hit(avs_address, vic_pkg::OFF_FFEN)) begin
            nxt_force = force_ff | (wdm & vic_pkg::FORCE_ALLOWED);
         end else if (hit(avs_address, vic_pkg::OFF_FFDIS)) begin
            nxt_force = force_ff & ~wdm;
         end
      end
      // Stacking saves the interrupted context and makes the new source current.
      if (do_push && (depth_ff < vic_pkg::DEPTH_W'(SN))) begin
         nxt_stk_lvl[3'(depth_ff)] = cur_lvl_ff;
         nxt_stk_src[3'(depth_ff)] = cur_src_ff;
         nxt_depth = depth_ff + 1'b1;
         nxt_cur_lvl = push_lvl;
         nxt_cur_src = push_src;
         clr_v[push_src] = 1'b1;
      end
      // A new edge in the same cycle as its clear is kept: set wins.
      nxt_edge_pend = set_v | (edge_pend_ff & ~clr_v);
      // The lines follow the new state one cycle later; the mask leaves wake alone.
      nxt_normal_request_line_n = !(active && !global_mask_bit_ff);
      nxt_fast_request_line_n = !(fast_hit && !global_mask_bit_ff);
      nxt_wake = |live;
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   // Synchronous reset returns every control register to zero, except waitrequest and the two lines, which reset high.
   always_ff @(posedge clock) begin
      sync1_ff <= src_in;
      sync2_ff <= sync1_ff;
      if (!reset_n) begin
         prev_ff <= '0;
         for (int i = 0; i < NSRC; i++) begin
            prio_ff[i] <= '0;
            trig_ff[i] <= '0;
            vector_ff[i] <= vic_pkg::RST_WORD;
         end
         for (int j = 0; j < SN; j++) begin
            stk_lvl_ff[j] <= '0;
            stk_src_ff[j] <= '0;
         end
         spu_ff <= vic_pkg::RST_WORD;
         protect_mode_bit_ff <= 1'b0;
         global_mask_bit_ff <= 1'b0;
         enabled_ff <= '0;
         force_ff <= '0;
         edge_pend_ff <= '0;
         cur_lvl_ff <= '0;
         cur_src_ff <= '0;
         depth_ff <= '0;
         memo_valid_ff <= 1'b0;
         memo_src_ff <= '0;
         memo_lvl_ff <= '0;
         wait_ff <= 1'b1;
         rdata_ff <= vic_pkg::RST_WORD;
         normal_request_line_n_ff <= 1'b1;
         fast_request_line_n_ff <= 1'b1;
         wake_ff <= 1'b0;
      end else begin
         prev_ff <= sync2_ff;
         prio_ff <= nxt_prio;
         trig_ff <= nxt_trig;
         vector_ff <= nxt_vector;
         stk_lvl_ff <= nxt_stk_lvl;
         stk_src_ff <= nxt_stk_src;
         spu_ff <= nxt_spu;
         protect_mode_bit_ff <= nxt_protect_mode_bit;
         global_mask_bit_ff <= nxt_global_mask_bit;
         enabled_ff <= nxt_enabled;
         force_ff <= nxt_force;
         edge_pend_ff <= nxt_edge_pend;
         cur_lvl_ff <= nxt_cur_lvl;
         cur_src_ff <= nxt_cur_src;
         depth_ff <= nxt_depth;
         memo_valid_ff <= nxt_memo_valid;
         memo_src_ff <= nxt_memo_src;
         memo_lvl_ff <= nxt_memo_lvl;
         wait_ff <= nxt_wait;
         rdata_ff <= nxt_rdata;
         normal_request_line_n_ff <= nxt_normal_request_line_n;
         fast_request_line_n_ff <= nxt_fast_request_line_n;
         wake_ff <= nxt_wake;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************
   // The window offset is the low 12 address bits; the system decoder places
   // it at the base, and everything in it is answered here.
   assign avs_readdata = rdata_ff;
   assign avs_waitrequest = wait_ff;
   assign normal_request_line_n = normal_request_line_n_ff;
   assign fast_request_line_n = fast_request_line_n_ff;
   assign wakeup_req = wake_ff;
endmodule : vic_ctrl

// [verification/vic_ctrl_assertions.sv]
// Checker for the bus timing and fixed status bits of the interrupt controller.
`timescale 1ns/100ps
module vic_ctrl_assertions #(parameter int NSRC = 32) (
   input logic clock,
   input logic reset_n,
   input logic [11:0] avs_address,
   input logic avs_read,
   input logic avs_write,
   input logic [31:0] avs_writedata,
   input logic [3:0] avs_byteenable,
   input logic [31:0] avs_readdata,
   input logic avs_waitrequest,
   input logic [NSRC-1:0] src_in,
   input logic normal_request_line_n,
   input logic fast_request_line_n,
   input logic wakeup_req
);
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   // A read is taken on an edge where waitrequest is still high.
   logic rd_go;
   logic [9:0] wa;
   assign rd_go = avs_read && avs_waitrequest;
   assign wa = avs_address[11:2];
   wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus answer late");
   wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low too long");
   wait_idle_a: assert property (!avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest)
      else $error("answer without request");
   data_hold_a: assert property (!rd_go |=> $stable(avs_readdata))
      else $error("read data moved");
   resv_zero_a: assert property (rd_go && wa inside {10'h046, 10'h047, 10'h04f, [10'h053:10'h3ff]}
      |=> avs_readdata == 32'h0) else $error("reserved word not zero");
   cmd_zero_a: assert property (rd_go && wa inside {[10'h048:10'h04c], 10'h050, 10'h051}
      |=> avs_readdata == 32'h0) else $error("command word readable");
   cur_upper_a: assert property (rd_go && wa == 10'h042 |=> avs_readdata[31:5] == 27'h0)
      else $error("source number upper bits set");
   mode_bits_a: assert property (rd_go && wa < 10'h020 |=> (avs_readdata & 32'hffff_ff98) == 0)
      else $error("mode word spare bits set");
endmodule : vic_ctrl_assertions

// [verification/vic_core_model.sv]
// Processor core model that counts the requests it sees on both lines.
`timescale 1ns/100ps
module vic_core_model (
   input logic normal_request_line_n,
   input logic fast_request_line_n,
   output int irq_taken,
   output int fiq_taken
);
   // Lines are active low, so each falling edge is one new request.
   initial begin
      irq_taken = 0;
      fiq_taken = 0;
   end
   always @(negedge normal_request_line_n) irq_taken++;
   always @(negedge fast_request_line_n) fiq_taken++;
endmodule : vic_core_model

// [verification/vic_ctrl_tb_top.sv]
// Self-checking testbench of the interrupt controller register block.
`timescale 1ns/100ps
module vic_ctrl_tb_top;
   logic clock = 0, reset_n = 0, avs_read = 0, avs_write = 0;
   logic [11:0] avs_address = 12'h0;
   logic [31:0] avs_writedata = 32'h0, src_in = 32'h0, avs_readdata, rd, v, w;
   logic [3:0] avs_byteenable = 4'hf;
   logic [4:0] s;
   logic avs_waitrequest, normal_request_line_n, fast_request_line_n, wakeup_req;
   int bad_count = 0, comparisons = 0, seed = 93541, irq_n, fiq_n;
   logic [11:0] zr[9] = '{12'h0, 12'h7c, 12'h80, 12'hfc, 12'h108, 12'h10c, 12'h110, 12'h134, 12'h138};
   logic [11:0] zz[9] = '{12'h118, 12'h11c, 12'h120, 12'h12c, 12'h130, 12'h13c, 12'h140, 12'h14c, 12'hffc};
   initial forever #4 clock = ~clock;
   vic_ctrl uut (.clock(clock), .reset_n(reset_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .src_in(src_in), .wakeup_req(wakeup_req),
      .normal_request_line_n(normal_request_line_n), .fast_request_line_n(fast_request_line_n));
   vic_core_model core (.normal_request_line_n(normal_request_line_n),
      .fast_request_line_n(fast_request_line_n), .irq_taken(irq_n), .fiq_taken(fiq_n));
   task automatic finish_test();
      $display("compared %0d, failed %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : finish_test
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // Holds the request until waitrequest is seen low at an edge.
   task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge clock);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= !wr;
      avs_write <= wr;
      for (k = 0; k < 20; k++) begin
         @(posedge clock);
         if (avs_waitrequest === 1'b0) break;
      end
      rd = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      if (k == 20) begin
         bad_count++;
         finish_test();
      end
   endtask : bus
   task automatic line_low(input logic f);
      int k;
      for (k = 0; k < 30 && (f ? fast_request_line_n : normal_request_line_n) !== 1'b0; k++)
         @(posedge clock);
      if (k == 30) begin
         bad_count++;
         finish_test();
      end
   endtask : line_low
   initial begin
      repeat (2) @(posedge clock);
      reset_n <= 1'b1;
      repeat (3) @(posedge clock);
      foreach (zr[i]) begin
         bus(1'b0, zr[i], 32'h0);
         chk("reset value", 32'h0, rd);
      end
      for (int i = 0; i < 8; i++) begin
         s = 5'($random(seed));
         v = $random(seed);
         bus(1'b1, {5'h01, s, 2'h0}, v);
         bus(1'b0, {5'h01, s, 2'h0}, 32'h0);
         chk("vector", v, rd);
         bus(1'b1, {5'h00, s, 2'h0}, v);
         bus(1'b0, {5'h00, s, 2'h0}, 32'h0);
         chk("mode", v & 32'h67, rd);
      end
      bus(1'b1, 12'h118, $random(seed));
      bus(1'b1, 12'h13c, $random(seed));
      foreach (zz[i]) begin
         bus(1'b0, zz[i], 32'h0);
         chk("empty word", 32'h0, rd);
      end
      v = $random(seed);
      bus(1'b1, 12'h120, v);
      bus(1'b1, 12'h124, v & 32'h0000_ffff);
      bus(1'b0, 12'h110, 32'h0);
      chk("enabled", v & 32'hffff_0000, rd);
      bus(1'b1, 12'h124, 32'hffff_ffff);
      $display("register test done");
      v = $random(seed);
      w = $random(seed);
      bus(1'b1, 12'h014, 32'h3);
      bus(1'b1, 12'h094, v);
      bus(1'b1, 12'h134, w);
      bus(1'b1, 12'h120, 32'h21);
      for (int p = 0; p < 2; p++) begin
         bus(1'b1, 12'h138, p);
         src_in[5] <= 1'b1;
         line_low(1'b0);
         bus(1'b0, 12'h10c, 32'h0);
         chk("pending", 32'h20, rd);
         bus(1'b0, 12'h100, 32'h0);
         chk("normal vector", v, rd);
         bus(1'b0, 12'h108, 32'h0);
         chk("current source", p ? 32'h0 : 32'h5, rd);
         if (p) bus(1'b1, 12'h100, 32'h0);
         bus(1'b0, 12'h108, 32'h0);
         chk("stacked source", 32'h5, rd);
         chk("normal line", 32'h1, normal_request_line_n);
         src_in[5] <= 1'b0;
         repeat (4) @(posedge clock);
         bus(1'b1, 12'h130, 32'h0);
         bus(1'b0, 12'h108, 32'h0);
         chk("popped source", 32'h0, rd);
         bus(1'b0, 12'h100, 32'h0);
         chk("spurious", w, rd);
         bus(1'b1, 12'h130, 32'h0);
      end
      $display("normal test done");
      bus(1'b1, 12'h000, 32'h0);
      bus(1'b1, 12'h080, v ^ w);
      src_in[0] <= 1'b1;
      line_low(1'b1);
      bus(1'b0, 12'h104, 32'h0);
      chk("fast vector", v ^ w, rd);
      bus(1'b1, 12'h138, 32'h2);
      repeat (4) @(posedge clock);
      chk("masked fast line", 32'h1, fast_request_line_n);
      chk("wakeup", 32'h1, wakeup_req);
      src_in[0] <= 1'b0;
      bus(1'b1, 12'h138, 32'h0);
      repeat (4) @(posedge clock);
      bus(1'b0, 12'h104, 32'h0);
      chk("fast spurious", w, rd);
      chk("core requests", 32'h21, {irq_n[3:0], fiq_n[3:0]});
      bus(1'b1, 12'h01c, 32'h20);
      bus(1'b1, 12'h12c, 32'h80);
      bus(1'b0, 12'h10c, 32'h0);
      chk("set pending", 32'h80, rd);
      bus(1'b1, 12'h128, 32'h80);
      bus(1'b0, 12'h10c, 32'h0);
      chk("cleared pending", 32'h0, rd);
      bus(1'b1, 12'h140, 32'hffff_ffff);
      bus(1'b0, 12'h148, 32'h0);
      chk("force state", 32'hffff_fffe, rd);
      $display("fast test done");
      finish_test();
   end
endmodule : vic_ctrl_tb_top
bind vic_ctrl vic_ctrl_assertions #(.NSRC(NSRC)) chk_i (.clock(clock), .reset_n(reset_n),
   .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
   .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .src_in(src_in),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .wakeup_req(wakeup_req),
   .normal_request_line_n(normal_request_line_n), .fast_request_line_n(fast_request_line_n));
